// file: include/esc_defines.vh
`ifndef ESC_DEFINES_VH
`define ESC_DEFINES_VH
// Clock rates and derived timing.
`define ESC_CLK_MHZ 100
`define ESC_BASE_MHZ 4
`define ESC_BASE_DIV (`ESC_CLK_MHZ / `ESC_BASE_MHZ)
`define ESC_MS_US 1000
`define ESC_MS_CYCLES (`ESC_MS_US * `ESC_CLK_MHZ)
`define ESC_DIV_MAX 3'h5
// Angle counter.
`define ESC_ANGLE_TICKS 1440
`define ESC_ANGLE_LAST 11'h59F
// Record fifo.
`define ESC_FIFO_DEPTH 16
`define ESC_FIFO_AW 4
`define ESC_REC_W 59
// Register offsets.
`define ESC_A_CTRL 12'h000
`define ESC_A_STAT 12'h004
`define ESC_A_POP 12'h008
`define ESC_A_HLVL 12'h00C
`define ESC_A_HTIME 12'h010
`define ESC_A_HANG 12'h014
`define ESC_A_TOPER 12'h018
`define ESC_A_TOANG 12'h01C
`define ESC_A_SEGWIN 12'h020
`define ESC_A_CHPOL 12'h024
`define ESC_A_CHSEG 12'h028
`define ESC_A_CHCHK 12'h02C
`define ESC_A_CHLVL 12'h030
`define ESC_A_TOVAL 12'h034
`define ESC_A_TOFLG 12'h038
`define ESC_A_TIME 12'h03C
`define ESC_A_ANGLE 12'h040
`define ESC_A_KNOCK0 12'h050
`define ESC_A_MEAS0 12'h080
// Field positions.
`define ESC_F_DIV 2:0
`define ESC_F_THRLO 4:3
`define ESC_F_THRHI 6:5
`define ESC_F_WLO 10:0
`define ESC_F_WHI 26:16
`define ESC_F_KPOL 31
`define ESC_F_OVF 7
// Reset values.
`define ESC_RST_TOPER 16'h000A
`define ESC_RST_WLO 11'h7FF
`define ESC_RST_WHI 11'h000
`define ESC_RST_TOVAL 16'h0000
`endif

// file: src/esc_fifo_mem.v
`timescale 1ns/1ns
`default_nettype none
`include "esc_defines.vh"

module esc_fifo_mem (
    input wire mclk,
    input wire wr_en,
    input wire [`ESC_FIFO_AW-1:0] wr_addr,
    input wire [`ESC_REC_W-1:0] wr_data,
    input wire [`ESC_FIFO_AW-1:0] rd_addr,
    output wire [`ESC_REC_W-1:0] rd_data
);

reg [`ESC_REC_W-1:0] mem [0:`ESC_FIFO_DEPTH-1];
reg [`ESC_REC_W-1:0] rd_ff;

// Write port and registered read port.
always @(posedge mclk) begin
    if (wr_en) begin
        mem[wr_addr] <= wr_data;
    end
    rd_ff <= mem[rd_addr];
end

assign rd_data = rd_ff;

endmodule // esc_fifo_mem
`default_nettype wire

// file: src/esc_chan.v
`timescale 1ns/1ns
`default_nettype none
`include "esc_defines.vh"

module esc_chan (
    input wire mclk,
    input wire sys_rst,
    input wire smp_stb,
    input wire lvl,
    input wire edge_det,
    input wire in_win,
    input wire seg_en,
    input wire hi_mode,
    input wire lvl_dep,
    input wire [15:0] to_value,
    input wire en_t,
    input wire en_a,
    input wire chk_t,
    input wire chk_a,
    output wire [15:0] meas,
    output wire to_pulse
);

reg [15:0] meas_ff;
reg [15:0] width_ff;
reg seen_t_ff;
reg seen_a_ff;
wire act;
wire act_new;
wire edge_ok;
wire to_now;

assign act = hi_mode ? lvl : ~lvl;
assign act_new = hi_mode ? ~lvl : lvl;
assign edge_ok = edge_det & (~seg_en | in_win);
assign to_now = (chk_t & en_t & ~seen_t_ff) | (chk_a & en_a & ~seen_a_ff);

always @(posedge mclk) begin
    if (sys_rst) begin
        meas_ff <= 16'h0000;
        width_ff <= 16'h0000;
        seen_t_ff <= 1'b0;
        seen_a_ff <= 1'b0;
    end else begin
        // An edge in the check cycle survives into the next interval.
        seen_t_ff <= edge_det | (seen_t_ff & ~chk_t);
        seen_a_ff <= edge_det | (seen_a_ff & ~chk_a);
        if (edge_ok & act_new) begin
            width_ff <= 16'h0000;
        end else if (smp_stb & act & (width_ff != 16'hFFFF)) begin
            width_ff <= width_ff + 16'h0001;
        end
        if (to_now) begin
            if (lvl_dep) begin
                meas_ff <= act ? 16'hFFFF : 16'h0000;
            end else begin
                meas_ff <= to_value;
            end
        end else if (edge_ok & ~act_new) begin
            meas_ff <= width_ff;
        end
    end
end

assign meas = meas_ff;
assign to_pulse = to_now;

endmodule // esc_chan
`default_nettype wire

// file: src/esc_top.v
// Operation
// - Two threshold selects, one for channels 0-7, one for 8-15, four options.
// - All sixteen levels sampled each sample tick and compared with previous.
// - Any change latches the sixteen levels of that same sample.
// - Each record carries the time counter and the angle counter.
// - Records go into a fifo read by software in arrival order.
// - High is inactive in low-time mode, low inactive in high-time mode.
// - Falling edge opens a low pulse, rising edge opens a high pulse.
// - Rising edge closes a low pulse, falling edge closes a high pulse.
// - Segmented evaluation only inside the lower and upper angle window limits.
// - Sixteen measurement channels, each bound to its own input.
// - Each channel has its own evaluation, timeout and segmenting settings.
// - A measurement changes only on edges or on a timeout.
// - At each check, a channel without edges since last check times out.
// - Timeout replaces the value by a fixed value or a level-derived one.
// - Level-dependent timeout reports 0.0 or 1.0 from the present level.
// - Checks run every set milliseconds or once per cycle at an angle.
// - Combined mode runs both checks; either failing declares a timeout.
// - Four knock enables asserted only while angle is inside their window.
// - Each knock enable has a selectable active polarity.
// - Angle counter steps once per tick, 1440 ticks per cycle.
// - Sampling runs from a 4 MHz tick, divisible by 1, 2, 4, 8, 16 or 32.
// - Active means low in low-time mode, high in high-time mode.
`timescale 1ns/1ns
`default_nettype none
`include "esc_defines.vh"

module esc_top #(
    parameter integer MS_CYCLES = `ESC_MS_CYCLES
) (
    input wire mclk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [15:0] chan_in,
    input wire angle_tick,
    output wire [1:0] thr_sel_lo,
    output wire [1:0] thr_sel_hi,
    output wire [3:0] knock_en
);

localparam integer BASE_LAST_I = `ESC_BASE_DIV - 1;
localparam integer MS_LAST_I = MS_CYCLES - 1;
localparam integer FIFO_DEPTH_I = `ESC_FIFO_DEPTH;
localparam [4:0] BASE_LAST = BASE_LAST_I[4:0];
localparam [16:0] MS_LAST = MS_LAST_I[16:0];
localparam [4:0] FIFO_FULL = FIFO_DEPTH_I[4:0];

////////////////////////////////////////////////////////////////////////////////

// Window test shared by the knock outputs and the channel segments.
function win_in;
    input [10:0] ang;
    input [10:0] lo;
    input [10:0] hi;
    begin
        win_in = (ang >= lo) && (ang <= hi);
    end
endfunction

// Mask of divided base ticks that are skipped.
function [4:0] div_mask;
    input [2:0] sel;
    begin
        case (sel)
            3'h0: div_mask = 5'h00;
            3'h1: div_mask = 5'h01;
            3'h2: div_mask = 5'h03;
            3'h3: div_mask = 5'h07;
            3'h4: div_mask = 5'h0F;
            default: div_mask = 5'h1F;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

reg [2:0] div_sel_ff;
reg [1:0] thr_lo_ff;
reg [1:0] thr_hi_ff;
reg [15:0] to_per_ff;
reg [10:0] to_ang_ff;
reg [10:0] seg_lo_ff;
reg [10:0] seg_hi_ff;
reg [15:0] ch_pol_ff;
reg [15:0] ch_seg_ff;
reg [15:0] ch_ent_ff;
reg [15:0] ch_ena_ff;
reg [15:0] ch_lvl_ff;
reg [15:0] to_val_ff;
reg [15:0] to_flg_ff;
reg ovf_ff;
reg [10:0] klo_ff [0:3];
reg [10:0] khi_ff [0:3];
reg [3:0] kpol_ff;
reg [3:0] knock_ff;
reg [31:0] rdata_ff;
reg slverr_ff;
reg [31:0] rd_mux;
reg rd_hit;
integer k;
integer kw;
integer kr;

wire wr_acc;
wire setup;
assign setup = psel & ~penable;
assign wr_acc = psel & penable & pwrite;
assign pready = 1'b1;
assign prdata = rdata_ff;
assign pslverr = slverr_ff;

////////////////////////////////////////////////////////////////////////////////

// Input synchroniser and sample timing.
reg [15:0] sync1_ff;
reg [15:0] sync2_ff;
reg [15:0] cur_ff;
reg tick1_ff;
reg tick2_ff;
reg tick3_ff;
reg [4:0] base_cnt_ff;
reg [4:0] div_cnt_ff;
reg [31:0] time_ff;
reg [10:0] angle_ff;
reg [10:0] nxt_angle;
wire base_tick;
wire smp_stb;
wire ang_step;
wire [15:0] chg;
wire push_req;

assign base_tick = (base_cnt_ff == BASE_LAST);
assign smp_stb = base_tick & ((div_cnt_ff & div_mask(div_sel_ff)) == 5'h00);
assign ang_step = tick2_ff & ~tick3_ff;
assign chg = sync2_ff ^ cur_ff;
assign push_req = smp_stb & (chg != 16'h0000);

always @* begin
    nxt_angle = angle_ff;
    if (ang_step) begin
        if (angle_ff == `ESC_ANGLE_LAST) begin
            nxt_angle = 11'h000;
        end else begin
            nxt_angle = angle_ff + 11'h001;
        end
    end
end

always @(posedge mclk) begin
    sync1_ff <= chan_in;
    sync2_ff <= sync1_ff;
    tick1_ff <= angle_tick;
    tick2_ff <= tick1_ff;
    if (sys_rst) begin
        cur_ff <= 16'h0000;
        tick3_ff <= 1'b0;
        base_cnt_ff <= 5'h00;
        div_cnt_ff <= 5'h00;
        time_ff <= 32'h00000000;
        angle_ff <= 11'h000;
    end else begin
        tick3_ff <= tick2_ff;
        base_cnt_ff <= base_tick ? 5'h00 : base_cnt_ff + 5'h01;
        if (base_tick) begin
            div_cnt_ff <= div_cnt_ff + 5'h01;
            time_ff <= time_ff + 32'h00000001;
        end
        if (smp_stb) begin
            cur_ff <= sync2_ff;
        end
        angle_ff <= nxt_angle;
    end
end

////////////////////////////////////////////////////////////////////////////////

// Record fifo: levels, time stamp and angle stamp.
reg [4:0] wr_ptr_ff;
reg [4:0] rd_ptr_ff;
wire [4:0] count;
wire fifo_full;
wire fifo_empty;
wire push;
wire pop;
wire [4:0] nxt_rd_ptr;
wire [`ESC_REC_W-1:0] rec_in;
wire [`ESC_REC_W-1:0] rec_out;

assign count = wr_ptr_ff - rd_ptr_ff;
assign fifo_full = (count == FIFO_FULL);
assign fifo_empty = (count == 5'h00);
assign push = push_req & ~fifo_full;
assign pop = wr_acc & (paddr == `ESC_A_POP) & ~fifo_empty;
assign nxt_rd_ptr = pop ? rd_ptr_ff + 5'h01 : rd_ptr_ff;
assign rec_in = {angle_ff, time_ff, sync2_ff};

always @(posedge mclk) begin
    if (sys_rst) begin
        wr_ptr_ff <= 5'h00;
        rd_ptr_ff <= 5'h00;
    end else begin
        if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 5'h01;
        end
        rd_ptr_ff <= nxt_rd_ptr;
    end
end

esc_fifo_mem u_mem (
    .mclk(mclk),
    .wr_en(push),
    .wr_addr(wr_ptr_ff[3:0]),
    .wr_data(rec_in),
    .rd_addr(nxt_rd_ptr[3:0]),
    .rd_data(rec_out)
);

////////////////////////////////////////////////////////////////////////////////

// Timeout check points in time and in angle.
reg [16:0] ms_cnt_ff;
reg [15:0] per_cnt_ff;
wire ms_tick;
wire chk_t;
wire chk_a;
wire seg_in;
wire [255:0] meas_bus;
wire [15:0] to_pulse;

assign ms_tick = (ms_cnt_ff == MS_LAST);
assign chk_t = ms_tick & (to_per_ff != 16'h0000) & (per_cnt_ff >= to_per_ff - 16'h0001);
assign chk_a = ang_step & (nxt_angle == to_ang_ff);
assign seg_in = win_in(angle_ff, seg_lo_ff, seg_hi_ff);

always @(posedge mclk) begin
    if (sys_rst) begin
        ms_cnt_ff <= 17'h00000;
        per_cnt_ff <= 16'h0000;
    end else begin
        ms_cnt_ff <= ms_tick ? 17'h00000 : ms_cnt_ff + 17'h00001;
        if (chk_t) begin
            per_cnt_ff <= 16'h0000;
        end else if (ms_tick) begin
            per_cnt_ff <= per_cnt_ff + 16'h0001;
        end
    end
end

genvar gi;
generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_ch
        esc_chan u_ch (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .smp_stb(smp_stb),
            .lvl(cur_ff[gi]),
            .edge_det(smp_stb & chg[gi]),
            .in_win(seg_in),
            .seg_en(ch_seg_ff[gi]),
            .hi_mode(ch_pol_ff[gi]),
            .lvl_dep(ch_lvl_ff[gi]),
            .to_value(to_val_ff),
            .en_t(ch_ent_ff[gi]),
            .en_a(ch_ena_ff[gi]),
            .chk_t(chk_t),
            .chk_a(chk_a),
            .meas(meas_bus[16*gi +: 16]),
            .to_pulse(to_pulse[gi])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////

// Knock enable outputs.
always @(posedge mclk) begin
    if (sys_rst) begin
        knock_ff <= 4'h0;
    end else begin
        for (k = 0; k < 4; k = k + 1) begin
            knock_ff[k] <= win_in(angle_ff, klo_ff[k], khi_ff[k]) ? kpol_ff[k] : ~kpol_ff[k];
        end
    end
end

assign knock_en = knock_ff;
assign thr_sel_lo = thr_lo_ff;
assign thr_sel_hi = thr_hi_ff;

////////////////////////////////////////////////////////////////////////////////

// Register writes.
always @(posedge mclk) begin
    if (sys_rst) begin
        div_sel_ff <= 3'h0;
        thr_lo_ff <= 2'h0;
        thr_hi_ff <= 2'h0;
        to_per_ff <= `ESC_RST_TOPER;
        to_ang_ff <= 11'h000;
        seg_lo_ff <= 11'h000;
        seg_hi_ff <= `ESC_ANGLE_LAST;
        ch_pol_ff <= 16'h0000;
        ch_seg_ff <= 16'h0000;
        ch_ent_ff <= 16'h0000;
        ch_ena_ff <= 16'h0000;
        ch_lvl_ff <= 16'h0000;
        to_val_ff <= `ESC_RST_TOVAL;
        to_flg_ff <= 16'h0000;
        ovf_ff <= 1'b0;
        kpol_ff <= 4'hF;
        for (kw = 0; kw < 4; kw = kw + 1) begin
            klo_ff[kw] <= `ESC_RST_WLO;
            khi_ff[kw] <= `ESC_RST_WHI;
        end
    end else begin
        if (wr_acc) begin
            case (paddr)
                `ESC_A_CTRL: begin
                    div_sel_ff <= (pwdata[`ESC_F_DIV] > `ESC_DIV_MAX) ? `ESC_DIV_MAX : pwdata[`ESC_F_DIV];
                    thr_lo_ff <= pwdata[`ESC_F_THRLO];
                    thr_hi_ff <= pwdata[`ESC_F_THRHI];
                end
                `ESC_A_TOPER: to_per_ff <= pwdata[15:0];
                `ESC_A_TOANG: to_ang_ff <= pwdata[`ESC_F_WLO];
                `ESC_A_SEGWIN: begin
                    seg_lo_ff <= pwdata[`ESC_F_WLO];
                    seg_hi_ff <= pwdata[`ESC_F_WHI];
                end
                `ESC_A_CHPOL: ch_pol_ff <= pwdata[15:0];
                `ESC_A_CHSEG: ch_seg_ff <= pwdata[15:0];
                `ESC_A_CHCHK: begin
                    ch_ent_ff <= pwdata[15:0];
                    ch_ena_ff <= pwdata[31:16];
                end
                `ESC_A_CHLVL: ch_lvl_ff <= pwdata[15:0];
                `ESC_A_TOVAL: to_val_ff <= pwdata[15:0];
                default: begin
                    for (kw = 0; kw < 4; kw = kw + 1) begin
                        if (paddr == `ESC_A_KNOCK0 + 4 * kw) begin
                            klo_ff[kw] <= pwdata[`ESC_F_WLO];
                            khi_ff[kw] <= pwdata[`ESC_F_WHI];
                            kpol_ff[kw] <= pwdata[`ESC_F_KPOL];
                        end
                    end
                end
            endcase
        end
        // A new event wins over a clear in the same cycle.
        if (push_req & fifo_full) begin
            ovf_ff <= 1'b1;
        end else if (wr_acc & (paddr == `ESC_A_STAT) & pwdata[`ESC_F_OVF]) begin
            ovf_ff <= 1'b0;
        end
        if (wr_acc & (paddr == `ESC_A_TOFLG)) begin
            to_flg_ff <= (to_flg_ff & ~pwdata[15:0]) | to_pulse;
        end else begin
            to_flg_ff <= to_flg_ff | to_pulse;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

// Register reads, captured in the setup cycle.
always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    kr = 0;
    case (paddr)
        `ESC_A_CTRL: rd_mux = {25'h0000000, thr_hi_ff, thr_lo_ff, div_sel_ff};
        `ESC_A_STAT: rd_mux = {24'h000000, ovf_ff, fifo_full, fifo_empty, count};
        `ESC_A_POP: rd_mux = 32'h00000000;
        `ESC_A_HLVL: rd_mux = {16'h0000, rec_out[15:0]};
        `ESC_A_HTIME: rd_mux = rec_out[47:16];
        `ESC_A_HANG: rd_mux = {21'h000000, rec_out[58:48]};
        `ESC_A_TOPER: rd_mux = {16'h0000, to_per_ff};
        `ESC_A_TOANG: rd_mux = {21'h000000, to_ang_ff};
        `ESC_A_SEGWIN: rd_mux = {5'h00, seg_hi_ff, 5'h00, seg_lo_ff};
        `ESC_A_CHPOL: rd_mux = {16'h0000, ch_pol_ff};
        `ESC_A_CHSEG: rd_mux = {16'h0000, ch_seg_ff};
        `ESC_A_CHCHK: rd_mux = {ch_ena_ff, ch_ent_ff};
        `ESC_A_CHLVL: rd_mux = {16'h0000, ch_lvl_ff};
        `ESC_A_TOVAL: rd_mux = {16'h0000, to_val_ff};
        `ESC_A_TOFLG: rd_mux = {16'h0000, to_flg_ff};
        `ESC_A_TIME: rd_mux = time_ff;
        `ESC_A_ANGLE: rd_mux = {21'h000000, angle_ff};
        default: begin
            rd_hit = 1'b0;
            for (kr = 0; kr < 4; kr = kr + 1) begin
                if (paddr == `ESC_A_KNOCK0 + 4 * kr) begin
                    rd_mux = {kpol_ff[kr], 4'h0, khi_ff[kr], 5'h00, klo_ff[kr]};
                    rd_hit = 1'b1;
                end
            end
            if ((paddr[11:6] == 6'h02) && (paddr[1:0] == 2'h0)) begin
                rd_mux = {16'h0000, meas_bus[16*paddr[5:2] +: 16]};
                rd_hit = 1'b1;
            end
        end
    endcase
end

always @(posedge mclk) begin
    if (sys_rst) begin
        rdata_ff <= 32'h00000000;
        slverr_ff <= 1'b0;
    end else if (setup) begin
        rdata_ff <= pwrite ? 32'h00000000 : rd_mux;
        slverr_ff <= ~rd_hit;
    end
end

endmodule // esc_top
`default_nettype wire

// file: test/esc_ecu_model.sv
`timescale 1ns/1ns
`default_nettype none
module esc_ecu_model (
    input wire logic mclk,
    output logic [15:0] chan_in,
    output logic angle_tick
);
    initial begin
        chan_in = 16'h0000;
        angle_tick = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // Drives new thresholded levels on all channels at once.
    task automatic set_levels(input logic [15:0] lv);
        @(posedge mclk);
        chan_in <= lv;
    endtask
    // Sends angle ticks, alternating short and long high phases.
    task automatic tick(input int n);
        for (int k = 0; k < n; k++) begin
            repeat (3) @(posedge mclk);
            angle_tick <= 1'b1;
            repeat (3 + 2 * (k % 2)) @(posedge mclk);
            angle_tick <= 1'b0;
        end
    endtask
endmodule // esc_ecu_model
`default_nettype wire

// file: test/esc_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module esc_top_properties #(
    parameter integer MS_CYCLES = 50
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] chan_in,
    input wire logic angle_tick,
    input wire logic [1:0] thr_sel_lo,
    input wire logic [1:0] thr_sel_hi,
    input wire logic [3:0] knock_en
);
    logic [3:0] quiet_ff;
    logic tick_ff;
    wire wr_acc = psel & penable & pwrite;
    // Counts cycles since the last tick change or register write.
    always @(posedge mclk) begin
        tick_ff <= angle_tick;
        if (sys_rst | wr_acc | (angle_tick != tick_ff)) quiet_ff <= 4'h0;
        else if (quiet_ff != 4'hF) quiet_ff <= quiet_ff + 4'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    ready_high_a: assert property (pready) else $error("pready low");
    thr_lo_src_a: assert property ($changed(thr_sel_lo) |-> $past(wr_acc && paddr == 12'h000))
        else $error("low threshold select moved without a write");
    thr_hi_src_a: assert property ($changed(thr_sel_hi) |-> $past(wr_acc && paddr == 12'h000))
        else $error("high threshold select moved without a write");
    thr_write_a: assert property (wr_acc && paddr == 12'h000 |=>
        thr_sel_lo == $past(pwdata[4:3]) && thr_sel_hi == $past(pwdata[6:5])) else $error("threshold write lost");
    knock_quiet_a: assert property ($changed(knock_en) |-> quiet_ff < 4'h8)
        else $error("knock enable moved without cause");
    knock_rst_a: assert property (disable iff (1'b0) sys_rst |=> knock_en == 4'h0)
        else $error("knock enable not idle after reset");
    err_unmap_a: assert property (psel && !penable && paddr == 12'hFFC |=> pslverr)
        else $error("unmapped access not flagged");
    err_map_a: assert property (psel && !penable && paddr == 12'h004 |=> !pslverr)
        else $error("mapped access flagged");
    wdata_zero_a: assert property (psel && !penable && pwrite |=> prdata == 32'h0)
        else $error("read data not zero on write");
    rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved in access phase");
endmodule // esc_top_properties
bind esc_top esc_top_properties #(.MS_CYCLES(MS_CYCLES)) u_esc_top_properties (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_in(chan_in), .angle_tick(angle_tick),
    .thr_sel_lo(thr_sel_lo), .thr_sel_hi(thr_sel_hi), .knock_en(knock_en));
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e; int t;} esc_exp_t;
    logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, angle_tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv, w;
    logic [15:0] chan_in, v;
    logic [15:0] lv [0:16];
    logic [1:0] thr_sel_lo, thr_sel_hi;
    logic [3:0] knock_en;
    int fails, comparisons, seed, i, t0;
    int tm [0:2];
    esc_exp_t exp_q [$];
    esc_exp_t x;
    esc_top #(.MS_CYCLES(50)) u_esc_top (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_in(chan_in), .angle_tick(angle_tick), .thr_sel_lo(thr_sel_lo), .thr_sel_hi(thr_sel_hi),
        .knock_en(knock_en));
    esc_ecu_model u_esc_ecu_model (.mclk(mclk), .chan_in(chan_in), .angle_tick(angle_tick));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m = 32'hFFFFFFFF,
        input int t = 0, input logic e = 1'b0);
        exp_q.push_back('{d, m, e, t});
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic results;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Takes the oldest note off the queue as each read completes.
    always @(posedge mclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            x = exp_q.pop_front();
            rv = prdata & x.m;
            if (x.t > 0 && rv <= x.d + x.t && rv + x.t >= x.d) rv = x.d;
            chk(rv, x.d & x.m);
            chk({31'h0, pslverr}, {31'h0, x.e});
        end
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        results();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h21D1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        sys_rst = 1'b1;
        repeat (5) @(posedge mclk);
        t0 = int'($time);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h20, 32'hFF);
        rd(12'h018, 32'hA);
        rd(12'h020, 32'h059F0000);
        rd(12'hFFC, 32'h0, 32'hFFFFFFFF, 0, 1'b1);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            w = $random(seed) & 32'h78;
            wr(12'h000, w);
            rd(12'h000, w);
            chk({30'h0, thr_sel_lo}, {30'h0, w[4:3]});
            chk({30'h0, thr_sel_hi}, {30'h0, w[6:5]});
        end
        wr(12'h000, 32'h7);
        rd(12'h000, 32'h5);
        wr(12'h000, 32'h0);
        wr(12'h02C, 32'h0);
        $display("test config done");
        u_esc_ecu_model.tick(5);
        v = 16'h0;
        for (i = 0; i < 3; i++) begin
            w = $random(seed) | 32'h1;
            v = v ^ w[15:0];
            lv[i] = v;
            u_esc_ecu_model.set_levels(v);
            tm[i] = int'(($time - t0) / 250) + 1;
            repeat (60) @(posedge mclk);
        end
        rd(12'h004, 32'h03, 32'hFF);
        for (i = 0; i < 3; i++) begin
            rd(12'h00C, {16'h0, lv[i]});
            rd(12'h010, tm[i], 32'hFFFFFFFF, 1);
            rd(12'h014, 32'h5);
            wr(12'h008, 32'h0);
        end
        $display("test capture done");
        for (i = 0; i < 17; i++) begin
            v = v ^ 16'h1;
            lv[i] = v;
            u_esc_ecu_model.set_levels(v);
            repeat (40) @(posedge mclk);
        end
        rd(12'h004, 32'hD0, 32'hFF);
        for (i = 0; i < 16; i++) begin
            rd(12'h00C, {16'h0, lv[i]});
            wr(12'h008, 32'h0);
        end
        rd(12'h004, 32'hA0, 32'hFF);
        wr(12'h004, 32'h80);
        rd(12'h004, 32'h20, 32'hFF);
        $display("test overflow done");
        wr(12'h024, 32'h2);
        u_esc_ecu_model.set_levels({v[15:2], 2'b01});
        repeat (60) @(posedge mclk);
        u_esc_ecu_model.set_levels({v[15:2], 2'b10});
        repeat (250) @(posedge mclk);
        u_esc_ecu_model.set_levels({v[15:2], 2'b01});
        repeat (125) @(posedge mclk);
        u_esc_ecu_model.set_levels({v[15:2], 2'b10});
        repeat (500) @(posedge mclk);
        u_esc_ecu_model.set_levels({v[15:2], 2'b01});
        repeat (500) @(posedge mclk);
        rd(12'h080, 32'd20, 32'hFFFF, 1);
        rd(12'h084, 32'd20, 32'hFFFF, 1);
        wr(12'h028, 32'h2);
        wr(12'h020, 32'h0);
        u_esc_ecu_model.set_levels({v[15:2], 2'b10});
        repeat (250) @(posedge mclk);
        u_esc_ecu_model.set_levels({v[15:2], 2'b01});
        repeat (60) @(posedge mclk);
        rd(12'h080, 32'd10, 32'hFFFF, 1);
        rd(12'h084, 32'd20, 32'hFFFF, 1);
        $display("test measure done");
        wr(12'h034, 32'h1234);
        wr(12'h018, 32'h1);
        wr(12'h030, 32'h8);
        wr(12'h02C, 32'hC);
        u_esc_ecu_model.set_levels({v[15:4], 1'b0, v[2], 2'b01});
        repeat (200) @(posedge mclk);
        rd(12'h088, 32'h1234, 32'hFFFF);
        rd(12'h08C, 32'hFFFF, 32'hFFFF);
        rd(12'h038, 32'hC, 32'hC);
        $display("test timeout done");
        wr(12'h02C, 32'h00200000);
        wr(12'h01C, 32'h3);
        u_esc_ecu_model.tick(1438);
        rd(12'h040, 32'h3);
        u_esc_ecu_model.tick(1440);
        rd(12'h094, 32'h1234, 32'hFFFF);
        wr(12'h050, 32'h80070005);
        wr(12'h054, 32'h00070005);
        for (i = 4; i < 10; i++) begin
            u_esc_ecu_model.tick(1);
            repeat (8) @(posedge mclk);
            chk({31'h0, knock_en[0]}, {31'h0, i >= 5 && i <= 7});
            chk({31'h0, knock_en[1]}, {31'h0, i < 5 || i > 7});
            chk({30'h0, knock_en[3:2]}, 32'h0);
        end
        rd(12'h040, 32'h9);
        $display("test angle done");
        results();
    end
endmodule // tb
`default_nettype wire
